// ==== rtl/bmr_pkg.sv ====
// register map constants, field positions, command codes and carrier types
// assumes a single 125 MHz clock and a byte-wide host register port
package bmr_pkg;

	localparam int unsigned BMR_ADDR_W     = 7;
	localparam int unsigned BMR_PAGE_BYTES = 32;
	localparam int unsigned BMR_FLASH_BYTES = 96;

	// region bases
	localparam logic [6:0] BMR_A_RAM_LAST   = 7'h1F;
	localparam logic [6:0] BMR_A_UFL_FIRST  = 7'h20;
	localparam logic [6:0] BMR_A_UFL_LAST   = 7'h5F;
	localparam logic [6:0] BMR_A_ID_FIRST   = 7'h78;

	// special function registers, plus the gain correction id byte
	localparam logic [6:0] BMR_A_TEMP_LO    = 7'h60;
	localparam logic [6:0] BMR_A_TEMP_HI    = 7'h61;
	localparam logic [6:0] BMR_A_FLASH_COMMAND       = 7'h62;
	localparam logic [6:0] BMR_A_CLR        = 7'h63;
	localparam logic [6:0] BMR_A_MODE       = 7'h64;
	localparam logic [6:0] BMR_A_CTC_LO     = 7'h65;
	localparam logic [6:0] BMR_A_CTC_HI     = 7'h66;
	localparam logic [6:0] BMR_A_DTC_LO     = 7'h67;
	localparam logic [6:0] BMR_A_DTC_HI     = 7'h68;
	localparam logic [6:0] BMR_A_SCR_LO     = 7'h69;
	localparam logic [6:0] BMR_A_SCR_HI     = 7'h6A;
	localparam logic [6:0] BMR_A_CCR_LO     = 7'h6B;
	localparam logic [6:0] BMR_A_CCR_HI     = 7'h6C;
	localparam logic [6:0] BMR_A_DCR_LO     = 7'h6D;
	localparam logic [6:0] BMR_A_DCR_HI     = 7'h6E;
	localparam logic [6:0] BMR_A_FPD        = 7'h6F;
	localparam logic [6:0] BMR_A_FPA        = 7'h70;
	localparam logic [6:0] BMR_A_BAT_LO     = 7'h71;
	localparam logic [6:0] BMR_A_BAT_HI     = 7'h72;
	localparam logic [6:0] BMR_A_GAIN       = 7'h79;

	// mode register bits
	localparam int unsigned BMR_MODE_PEN    = 7;
	localparam int unsigned BMR_MODE_PST    = 6;
	localparam int unsigned BMR_MODE_CSLOW  = 5;
	localparam int unsigned BMR_MODE_DSLOW  = 4;
	localparam int unsigned BMR_MODE_POR    = 0;
	localparam logic [7:0]  BMR_MODE_WMASK  = 8'hCF;
	localparam logic [7:0]  BMR_MODE_RESET  = 8'h01;

	// clear register bits, order matches the counter index
	localparam int unsigned BMR_CNT_DCR     = 0;
	localparam int unsigned BMR_CNT_CCR     = 1;
	localparam int unsigned BMR_CNT_SCR     = 2;
	localparam int unsigned BMR_CNT_DTC     = 3;
	localparam int unsigned BMR_CNT_CTC     = 4;
	localparam int unsigned BMR_NUM_CNT     = 5;
	localparam logic [7:0]  BMR_CLR_MASK    = 8'h1F;
	localparam logic [7:0]  BMR_TEMP_HI_MASK = 8'h07;

	// command codes
	localparam logic [7:0] BMR_CMD_PROG     = 8'h0F;
	localparam logic [7:0] BMR_CMD_ERASE0   = 8'h40;
	localparam logic [7:0] BMR_CMD_ERASE1   = 8'h41;
	localparam logic [7:0] BMR_CMD_ERASE2   = 8'h42;
	localparam logic [7:0] BMR_CMD_SAVE     = 8'h45;
	localparam logic [7:0] BMR_CMD_LOAD     = 8'h48;
	localparam logic [7:0] BMR_CMD_SLEEP    = 8'hF6;
	localparam logic [7:0] BMR_ZERO_BYTE    = 8'h00;
	localparam logic [7:0] BMR_ERASED_BYTE  = 8'hFF;

	typedef enum logic [2:0] {
		BMR_ST_IDLE  = 3'b000,
		BMR_ST_LOAD  = 3'b001,
		BMR_ST_SAVE  = 3'b010,
		BMR_ST_PROG  = 3'b011,
		BMR_ST_ERASE = 3'b100
	} bmr_state_t;

	// host byte port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} bmr_req_t;

	// measurement results from the analog front end
	typedef struct packed {
		logic [10:0] voltage;
		logic        offset_sign;
		logic [3:0]  offset_mag;
		logic [10:0] temperature;
	} bmr_meas_t;

endpackage : bmr_pkg

// ==== rtl/bmr_flash_array.sv ====
// 96-byte flash model: three 32-byte pages, AND-only programming, page erase
// assumes the caller never programs and erases in the same cycle
`timescale 1ns/10ps
module bmr_flash_array
	import bmr_pkg::*;
(
	input  wire logic       ref_clk_in,
	input  wire logic       prog_in,
	input  wire logic [6:0] prog_addr_in,
	input  wire logic [7:0] prog_data_in,
	input  wire logic       erase_in,
	input  wire logic [1:0] erase_page_in,
	input  wire logic [6:0] rd_a_addr_in,
	output logic      [7:0] rd_a_data_out,
	input  wire logic [6:0] rd_b_addr_in,
	output logic      [7:0] rd_b_data_out
);

	// contents are nonvolatile, so reset leaves them untouched
	logic [7:0] cell_mem [BMR_FLASH_BYTES];

	assign rd_a_data_out = cell_mem[rd_a_addr_in];
	assign rd_b_data_out = cell_mem[rd_b_addr_in];

	always_ff @(posedge ref_clk_in)
	begin
		if (erase_in)
		begin
			for (int i = 0; i < BMR_PAGE_BYTES; i++)
				cell_mem[{erase_page_in, 5'(i)}] <= BMR_ERASED_BYTE;
		end
		else if (prog_in)
			cell_mem[prog_addr_in] <= prog_data_in & cell_mem[prog_addr_in];
	end

endmodule : bmr_flash_array

// ==== rtl/bmr_register_bank.sv ====
// host-visible register bank: id bytes, shadowed ram, user flash, counters, command engine
// assumes the serial link decoder presents one-cycle read/write strobes synchronous to ref_clk_in
`timescale 1ns/10ps

// Operation
// - 123 valid byte locations, seven-bit address, eight bits each.
// - nineteen special function registers sit in the upper address region.
// - addresses 0x78..0x7F are eight factory id bytes including gain correction.
// - top id byte is the device code; id bytes are read-only.
// - byte 0x79 returns the two's-complement gain correction value.
// - 0x00..0x1F is host read/write ram shadowed by flash page 0.
// - 0x20..0x3F is flash page 1, 0x40..0x5F flash page 2, readable.
// - sixty-four bytes of user flash arranged as two banks.
// - 0x72 holds offset sign, magnitude, voltage high bits; 0x71 voltage low.
// - five 16-bit counters appear as high/low byte pairs at fixed addresses.
// - mode byte holds port enable, port state, slow bits, wake threshold, power-on flag.
// - clear byte has reserved bits 7..5 and five clear-request bits.
// - temperature at 0x61/0x60; high byte carries only bits 2..0.
// - writing a code to the command byte starts the selected operation.
// - code 0x0F programs exactly one user flash byte.
// - codes 0x40, 0x41, 0x42 erase flash page 0, 1, 2.
// - code 0x45 copies all 32 ram bytes into flash page 0.
// - code 0x48 copies flash page 0 into the 32 ram bytes.
// - code 0xF6 enters the low-power state.
// - after power-on reset flash page 0 is loaded into ram before access.
// - byte programming stores data AND existing flash byte at the given address.
// - ram-to-flash transfer stores ram AND existing flash; erase first.
// - writing 1 to a clear bit zeroes that counter and self-clears the bit.
// - clearing a time counter also clears its slow bit.
module bmr_register_bank
	import bmr_pkg::*;
#(
	parameter logic [7:0] ID_DEVICE_CODE = 8'h5A, // arbitrary value
	parameter logic [7:0] ID_GAIN_CORR   = 8'h00, // arbitrary value
	parameter logic [7:0] ID_SERIAL_SEED = 8'hA5  // arbitrary value
)
(
	input  wire logic       ref_clk_in,
	input  wire logic       srst_in,
	input  wire bmr_req_t   req_in,
	output logic      [7:0] rdata_out,
	output logic            rvalid_out,
	output logic            busy_out,
	input  wire bmr_meas_t  meas_in,
	input  wire logic [4:0] cnt_tick_in,
	output logic            charge_slow_out,
	output logic            discharge_slow_out,
	output logic [2:0]      wake_threshold_out,
	output logic            sleep_out,
	input  wire logic       port_pin_in,
	output logic            port_pin_out,
	output logic            port_pin_oe_out
);

	////////////////////////////////////////////////////////////////////////////
	// address decode

	function automatic logic is_user_flash(input logic [6:0] a);
		return (a >= BMR_A_UFL_FIRST) && (a <= BMR_A_UFL_LAST);
	endfunction : is_user_flash

	function automatic logic [7:0] id_byte(input logic [2:0] idx);
		case (idx)
			3'h7:    return ID_DEVICE_CODE;
			3'h6:    return BMR_ZERO_BYTE;
			3'h1:    return ID_GAIN_CORR;
			default: return ID_SERIAL_SEED ^ {5'h00, idx};
		endcase
	endfunction : id_byte

	////////////////////////////////////////////////////////////////////////////
	// state

	bmr_state_t  state_reg,    state_next;
	logic [4:0]  idx_reg,      idx_next;
	logic [1:0]  page_reg,     page_next;
	logic [7:0]  flash_command_reg,     flash_command_next;
	logic [7:0]  clr_reg,      clr_next;
	logic [7:0]  mode_reg,     mode_next;
	logic [7:0]  fpd_reg,      fpd_next;
	logic [7:0]  fpa_reg,      fpa_next;
	logic [15:0] cnt_reg [BMR_NUM_CNT];
	logic [15:0] cnt_next [BMR_NUM_CNT];
	logic        sleep_reg,    sleep_next;
	logic [7:0]  rdata_reg,    rdata_next;
	logic        rvalid_reg,   rvalid_next;

	logic [7:0]  ram_mem [BMR_PAGE_BYTES];
	logic        ram_we;
	logic [4:0]  ram_waddr;
	logic [7:0]  ram_wdata;

	logic        fl_prog;
	logic [6:0]  fl_prog_addr;
	logic [7:0]  fl_prog_data;
	logic        fl_erase;
	logic [7:0]  fl_host_data;
	logic [7:0]  fl_eng_data;
	logic [7:0]  rd_byte;
	logic        host_wr;

	bmr_flash_array u_flash (
		.ref_clk_in    (ref_clk_in),
		.prog_in       (fl_prog),
		.prog_addr_in  (fl_prog_addr),
		.prog_data_in  (fl_prog_data),
		.erase_in      (fl_erase),
		.erase_page_in (page_reg),
		.rd_a_addr_in  (req_in.addr),
		.rd_a_data_out (fl_host_data),
		.rd_b_addr_in  ({2'b00, idx_reg}),
		.rd_b_data_out (fl_eng_data)
	);

	// writes during a flash operation are dropped so the engine sees stable operands
	assign host_wr = req_in.wr && (state_reg == BMR_ST_IDLE);

	////////////////////////////////////////////////////////////////////////////
	// read mux

	always_comb
	begin
		rd_byte = BMR_ZERO_BYTE;
		if (req_in.addr <= BMR_A_RAM_LAST)
			rd_byte = ram_mem[req_in.addr[4:0]];
		else if (is_user_flash(req_in.addr))
			rd_byte = fl_host_data;
		else if (req_in.addr >= BMR_A_ID_FIRST)
			rd_byte = id_byte(req_in.addr[2:0]);
		else
		begin
			case (req_in.addr)
				BMR_A_TEMP_LO: rd_byte = meas_in.temperature[7:0];
				BMR_A_TEMP_HI: rd_byte = {5'h00, meas_in.temperature[10:8]};
				BMR_A_FLASH_COMMAND:    rd_byte = flash_command_reg;
				BMR_A_CLR:     rd_byte = clr_reg & BMR_CLR_MASK;
				BMR_A_MODE:    rd_byte = {mode_reg[7], mode_reg[7] ? mode_reg[6] : port_pin_in,
					mode_reg[5:0]};
				BMR_A_CTC_LO:  rd_byte = cnt_reg[BMR_CNT_CTC][7:0];
				BMR_A_CTC_HI:  rd_byte = cnt_reg[BMR_CNT_CTC][15:8];
				BMR_A_DTC_LO:  rd_byte = cnt_reg[BMR_CNT_DTC][7:0];
				BMR_A_DTC_HI:  rd_byte = cnt_reg[BMR_CNT_DTC][15:8];
				BMR_A_SCR_LO:  rd_byte = cnt_reg[BMR_CNT_SCR][7:0];
				BMR_A_SCR_HI:  rd_byte = cnt_reg[BMR_CNT_SCR][15:8];
				BMR_A_CCR_LO:  rd_byte = cnt_reg[BMR_CNT_CCR][7:0];
				BMR_A_CCR_HI:  rd_byte = cnt_reg[BMR_CNT_CCR][15:8];
				BMR_A_DCR_LO:  rd_byte = cnt_reg[BMR_CNT_DCR][7:0];
				BMR_A_DCR_HI:  rd_byte = cnt_reg[BMR_CNT_DCR][15:8];
				BMR_A_FPD:     rd_byte = fpd_reg;
				BMR_A_FPA:     rd_byte = fpa_reg;
				BMR_A_BAT_LO:  rd_byte = meas_in.voltage[7:0];
				BMR_A_BAT_HI:  rd_byte = {meas_in.offset_sign, meas_in.offset_mag,
					meas_in.voltage[10:8]};
				default:       rd_byte = BMR_ZERO_BYTE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// host registers, counters and command engine

	always_comb
	begin
		state_next   = state_reg;
		idx_next     = idx_reg;
		page_next    = page_reg;
		flash_command_next    = flash_command_reg;
		clr_next     = clr_reg;
		mode_next    = mode_reg;
		fpd_next     = fpd_reg;
		fpa_next     = fpa_reg;
		cnt_next     = cnt_reg;
		sleep_next   = sleep_reg;
		rdata_next   = rdata_reg;
		rvalid_next  = req_in.rd;
		ram_we       = 1'b0;
		ram_waddr    = req_in.addr[4:0];
		ram_wdata    = req_in.wdata;
		fl_prog      = 1'b0;
		fl_prog_addr = fpa_reg[6:0];
		fl_prog_data = fpd_reg;
		fl_erase     = 1'b0;

		if (req_in.rd)
			rdata_next = rd_byte;
		// any link activity wakes the device
		if (req_in.rd || req_in.wr)
			sleep_next = 1'b0;

		// counters: clear wins over a tick in the same cycle
		for (int c = 0; c < BMR_NUM_CNT; c++)
		begin
			if (clr_reg[c])
			begin
				cnt_next[c] = 16'h0000;
				clr_next[c] = 1'b0;
			end
			else if (cnt_tick_in[c])
				cnt_next[c] = cnt_reg[c] + 16'h0001;
		end
		if (cnt_tick_in[BMR_CNT_CTC] && !clr_reg[BMR_CNT_CTC] && (cnt_reg[BMR_CNT_CTC] == 16'hFFFF))
			mode_next[BMR_MODE_CSLOW] = 1'b1;
		if (cnt_tick_in[BMR_CNT_DTC] && !clr_reg[BMR_CNT_DTC] && (cnt_reg[BMR_CNT_DTC] == 16'hFFFF))
			mode_next[BMR_MODE_DSLOW] = 1'b1;
		if (clr_reg[BMR_CNT_CTC])
			mode_next[BMR_MODE_CSLOW] = 1'b0;
		if (clr_reg[BMR_CNT_DTC])
			mode_next[BMR_MODE_DSLOW] = 1'b0;

		// host writes; id bytes and reserved locations have no storage
		if (host_wr)
		begin
			if (req_in.addr <= BMR_A_RAM_LAST)
				ram_we = 1'b1;
			case (req_in.addr)
				BMR_A_CLR:  clr_next = clr_next | (req_in.wdata & BMR_CLR_MASK);
				BMR_A_MODE: mode_next = (req_in.wdata & BMR_MODE_WMASK) |
					(mode_next & ~BMR_MODE_WMASK);
				BMR_A_FPD:  fpd_next = req_in.wdata;
				BMR_A_FPA:  fpa_next = req_in.wdata;
				BMR_A_FLASH_COMMAND:
				begin
					flash_command_next = req_in.wdata;
					case (req_in.wdata)
						BMR_CMD_PROG:
						begin
							if (is_user_flash(fpa_reg[6:0]) && !fpa_reg[7])
								state_next = BMR_ST_PROG;
						end
						BMR_CMD_ERASE0, BMR_CMD_ERASE1, BMR_CMD_ERASE2:
						begin
							state_next = BMR_ST_ERASE;
							page_next  = req_in.wdata[1:0];
						end
						BMR_CMD_SAVE:
						begin
							state_next = BMR_ST_SAVE;
							idx_next   = 5'h00;
						end
						BMR_CMD_LOAD:
						begin
							state_next = BMR_ST_LOAD;
							idx_next   = 5'h00;
						end
						BMR_CMD_SLEEP: sleep_next = 1'b1;
						default:       state_next = BMR_ST_IDLE;
					endcase
				end
				default: ;
			endcase
		end

		case (state_reg)
			BMR_ST_IDLE: ;
			BMR_ST_PROG:
			begin
				fl_prog    = 1'b1;
				state_next = BMR_ST_IDLE;
			end
			BMR_ST_ERASE:
			begin
				fl_erase   = 1'b1;
				state_next = BMR_ST_IDLE;
			end
			BMR_ST_SAVE:
			begin
				fl_prog      = 1'b1;
				fl_prog_addr = {2'b00, idx_reg};
				fl_prog_data = ram_mem[idx_reg];
				idx_next     = idx_reg + 5'h01;
				if (idx_reg == 5'h1F)
					state_next = BMR_ST_IDLE;
			end
			BMR_ST_LOAD:
			begin
				ram_we     = 1'b1;
				ram_waddr  = idx_reg;
				ram_wdata  = fl_eng_data;
				idx_next   = idx_reg + 5'h01;
				if (idx_reg == 5'h1F)
					state_next = BMR_ST_IDLE;
			end
			default: state_next = BMR_ST_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge ref_clk_in)
	begin
		if (srst_in)
		begin
			state_reg  <= BMR_ST_LOAD;
			idx_reg    <= 5'h00;
			page_reg   <= 2'b00;
			flash_command_reg   <= BMR_ZERO_BYTE;
			clr_reg    <= BMR_ZERO_BYTE;
			mode_reg   <= BMR_MODE_RESET;
			fpd_reg    <= BMR_ZERO_BYTE;
			fpa_reg    <= BMR_ZERO_BYTE;
			for (int c = 0; c < BMR_NUM_CNT; c++)
				cnt_reg[c] <= 16'h0000;
			sleep_reg  <= 1'b0;
			rdata_reg  <= BMR_ZERO_BYTE;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			state_reg  <= state_next;
			idx_reg    <= idx_next;
			page_reg   <= page_next;
			flash_command_reg   <= flash_command_next;
			clr_reg    <= clr_next;
			mode_reg   <= mode_next;
			fpd_reg    <= fpd_next;
			fpa_reg    <= fpa_next;
			cnt_reg    <= cnt_next;
			sleep_reg  <= sleep_next;
			rdata_reg  <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// ram holds no reset value; the power-on load fills it
	always_ff @(posedge ref_clk_in)
	begin
		if (ram_we && !srst_in)
			ram_mem[ram_waddr] <= ram_wdata;
	end

	assign rdata_out          = rdata_reg;
	assign rvalid_out         = rvalid_reg;
	assign busy_out           = (state_reg != BMR_ST_IDLE);
	assign charge_slow_out    = mode_reg[BMR_MODE_CSLOW];
	assign discharge_slow_out = mode_reg[BMR_MODE_DSLOW];
	assign wake_threshold_out = mode_reg[3:1];
	assign sleep_out          = sleep_reg;
	assign port_pin_out       = mode_reg[BMR_MODE_PST];
	assign port_pin_oe_out    = mode_reg[BMR_MODE_PEN];

	////////////////////////////////////////////////////////////////////////////
	// checks

	AST_ID_CODE: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		req_in.rd && (req_in.addr == 7'h7F) |=> rdata_out == ID_DEVICE_CODE)
		else $error("device code byte read back wrong");

	AST_GAIN_BYTE: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		req_in.rd && (req_in.addr == BMR_A_GAIN) |=> rdata_out == ID_GAIN_CORR)
		else $error("gain correction byte read back wrong");

	AST_RSVD_ZERO: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		req_in.rd && (req_in.addr > BMR_A_BAT_HI) && (req_in.addr < BMR_A_ID_FIRST)
		|=> rdata_out == 8'h00)
		else $error("reserved address did not read as zero");

	AST_TEMP_HI: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		req_in.rd && (req_in.addr == BMR_A_TEMP_HI) |=> rdata_out[7:3] == 5'h00)
		else $error("temperature high byte reserved bits set");

	AST_CLR_DONE: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		clr_reg[BMR_CNT_DCR] |=> !clr_reg[BMR_CNT_DCR] && (cnt_reg[BMR_CNT_DCR] == 16'h0000))
		else $error("discharge counter clear did not complete");

	AST_SLOW_CLR: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		clr_reg[BMR_CNT_DTC] |=> !discharge_slow_out)
		else $error("discharge slow bit survived a clear");

	AST_POR_LOAD: assert property (@(posedge ref_clk_in)
		$fell(srst_in) |-> busy_out ##[31:32] !busy_out)
		else $error("power-on page load did not run for one page");

	AST_SLEEP: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		host_wr && (req_in.addr == BMR_A_FLASH_COMMAND) && (req_in.wdata == BMR_CMD_SLEEP) |=> sleep_out)
		else $error("sleep command did not enter low power");

	AST_BAD_CMD: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		host_wr && (req_in.addr == BMR_A_FLASH_COMMAND) && (req_in.wdata == 8'h33)
		|=> (state_reg == BMR_ST_IDLE) && !sleep_out)
		else $error("unknown command changed state");

	AST_SAVE_LEN: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		host_wr && (req_in.addr == BMR_A_FLASH_COMMAND) && (req_in.wdata == BMR_CMD_SAVE)
		|=> (state_reg == BMR_ST_SAVE) ##32 (state_reg == BMR_ST_IDLE))
		else $error("page save did not take 32 cycles");

endmodule : bmr_register_bank

// ==== sim/bmr_host_model.sv ====
// host side of the register port: byte reads, byte writes, busy wait
// assumes one clock; requests launch just after a rising edge
`timescale 1ns/10ps
module bmr_host_model
	import bmr_pkg::*;
(
	input  wire logic       ref_clk_in,
	input  wire logic [7:0] rdata_in,
	input  wire logic       rvalid_in,
	input  wire logic       busy_in,
	output bmr_req_t        req_out
);
	initial req_out = '0;

	////////////////////////////////////////////////////////////////////////////////
	// released address/data flip so stale values never look valid
	task automatic idle_port;
		req_out <= {2'b00, ~req_out.addr, ~req_out.wdata};
	endtask : idle_port

	task automatic write_byte(input logic [6:0] addr, input logic [7:0] data);
		@(posedge ref_clk_in);
		req_out <= {2'b10, addr, data};
		@(posedge ref_clk_in);
		idle_port();
	endtask : write_byte

	// answer sampled one edge after the strobe edge
	task automatic read_byte(input logic [6:0] addr, output logic [7:0] data);
		@(posedge ref_clk_in);
		req_out <= {2'b01, addr, ~req_out.wdata};
		@(posedge ref_clk_in);
		idle_port();
		@(posedge ref_clk_in);
		data = (rvalid_in === 1'b1) ? rdata_in : 8'hxx;
	endtask : read_byte

	// bounded wait; counts busy cycles seen at falling edges
	task automatic wait_idle(output int unsigned cycles);
		cycles = 0;
		@(negedge ref_clk_in);
		while (busy_in !== 1'b0 && cycles < 200)
		begin
			@(negedge ref_clk_in);
			cycles++;
		end
	endtask : wait_idle
endmodule : bmr_host_model

// ==== sim/test_battery_monitor_register_map.sv ====
// self-checking bench: map, measurements, counters, commands, reset load
// assumes bmr_host_model drives the byte port
`timescale 1ns/10ps
module test_battery_monitor_register_map;
	import bmr_pkg::*;

	localparam logic [7:0] DEV_CODE = 8'h3C; // arbitrary value
	localparam logic [7:0] GAIN     = 8'hE3; // arbitrary value

	logic        ref_clk_in = 1'b0;
	logic        srst_in    = 1'b1;
	bmr_req_t    req;
	logic [7:0]  rdata;
	logic        rvalid, busy, cslow, dslow, sleep, pin_out, pin_oe;
	logic        pin_in     = 1'b0;
	logic [2:0]  wake;
	bmr_meas_t   meas       = '0;
	logic [4:0]  tick       = 5'h00;
	int unsigned n_errors   = 0;
	int unsigned n_tests    = 0;
	int unsigned cycles     = 0;
	int unsigned nb;

	always #4 ref_clk_in = ~ref_clk_in;

	bmr_register_bank #(.ID_DEVICE_CODE(DEV_CODE), .ID_GAIN_CORR(GAIN)) bmr_register_bank_i (
		.ref_clk_in(ref_clk_in), .srst_in(srst_in), .req_in(req), .rdata_out(rdata),
		.rvalid_out(rvalid), .busy_out(busy), .meas_in(meas), .cnt_tick_in(tick),
		.charge_slow_out(cslow), .discharge_slow_out(dslow), .wake_threshold_out(wake),
		.sleep_out(sleep), .port_pin_in(pin_in), .port_pin_out(pin_out), .port_pin_oe_out(pin_oe));

	bmr_host_model bmr_host_model_i (.ref_clk_in(ref_clk_in), .rdata_in(rdata),
		.rvalid_in(rvalid), .busy_in(busy), .req_out(req));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check8

	task automatic check1(input logic got, input logic exp);
		check8({7'h00, got}, {7'h00, exp});
	endtask : check1

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop

	// cut a hang; the whole run needs about 70k cycles
	always @(posedge ref_clk_in)
	begin
		cycles++;
		if (cycles == 90000)
		begin
			n_errors++;
			report_and_stop();
		end
	end

	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		bmr_host_model_i.write_byte(a, v);
	endtask : wr

	task automatic expect_rd(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] v;
		bmr_host_model_i.read_byte(a, v);
		check8(v, e);
	endtask : expect_rd

	task automatic wait_op;
		bmr_host_model_i.wait_idle(nb);
		check1(nb < 200, 1'b1);
	endtask : wait_op

	task automatic pulse(input int idx, input int n);
		@(posedge ref_clk_in);
		tick <= 5'(1 << idx);
		repeat (n) @(posedge ref_clk_in);
		tick <= 5'h00;
	endtask : pulse

	////////////////////////////////////////////////////////////////////////////////
	task automatic do_reset;
		srst_in <= 1'b1;
		repeat (6) @(posedge ref_clk_in);
		srst_in <= 1'b0;
		@(negedge ref_clk_in);
		check1(busy, 1'b1);
		wait_op();
		check1(nb > 30 && nb < 34, 1'b1);
		$display("test reset done");
	endtask : do_reset

	task automatic t_id;
		expect_rd(7'h7F, DEV_CODE);
		expect_rd(BMR_A_GAIN, GAIN);
		expect_rd(7'h7E, 8'h00);
		wr(7'h7F, 8'h00);
		expect_rd(7'h7F, DEV_CODE);
		for (int a = 7'h73; a <= 7'h77; a++)
		begin
			wr(7'(a), 8'hFF);
			expect_rd(7'(a), 8'h00);
		end
		$display("test id done");
	endtask : t_id

	task automatic t_meas;
		@(posedge ref_clk_in);
		meas <= {11'h5A3, 1'b1, 4'hA, 11'h6C5};
		wr(BMR_A_BAT_LO, 8'h00);
		expect_rd(BMR_A_BAT_LO, 8'hA3);
		expect_rd(BMR_A_BAT_HI, 8'hD5);
		expect_rd(BMR_A_TEMP_LO, 8'hC5);
		expect_rd(BMR_A_TEMP_HI, 8'h06);
		$display("test meas done");
	endtask : t_meas

	task automatic t_mode;
		wr(BMR_A_MODE, 8'hFF);
		expect_rd(BMR_A_MODE, 8'hCF);
		check8({pin_oe, pin_out, 3'h0, wake}, 8'hC7);
		@(posedge ref_clk_in);
		pin_in <= 1'b1;
		wr(BMR_A_MODE, 8'h0E);
		expect_rd(BMR_A_MODE, 8'h4E);
		check1(pin_oe, 1'b0);
		$display("test mode done");
	endtask : t_mode

	// counter index i: low byte at 0x6D - 2i, high byte right above
	task automatic t_counters;
		for (int i = 0; i < 5; i++)
		begin
			pulse(i, 259 + i);
			expect_rd(7'(8'h6D - 2 * i), 8'(3 + i));
			expect_rd(7'(8'h6E - 2 * i), 8'h01);
			wr(BMR_A_CLR, 8'(1 << i));
			expect_rd(BMR_A_CLR, 8'h00);
			expect_rd(7'(8'h6D - 2 * i), 8'h00);
			expect_rd(7'(8'h6E - 2 * i), 8'h00);
		end
		wr(BMR_A_CLR, 8'hE0);
		expect_rd(BMR_A_CLR, 8'h00);
		$display("test counters done");
	endtask : t_counters

	// full rollover costs 64k cycles, so only the discharge timer
	task automatic t_slow;
		pulse(BMR_CNT_DTC, 65536);
		expect_rd(BMR_A_MODE, 8'h5E);
		check1(dslow, 1'b1);
		check1(cslow, 1'b0);
		wr(BMR_A_CLR, 8'h08);
		expect_rd(BMR_A_MODE, 8'h4E);
		check1(dslow, 1'b0);
		$display("test slow done");
	endtask : t_slow

	task automatic t_flash;
		for (int p = 1; p < 3; p++)
		begin
			wr(BMR_A_FLASH_COMMAND, 8'(8'h40 + p));
			wait_op();
			expect_rd(7'(32 * p), 8'hFF);
			expect_rd(7'(32 * p + 31), 8'hFF);
			wr(BMR_A_FPD, 8'h3C);
			wr(BMR_A_FPA, 8'(32 * p + 5));
			wr(BMR_A_FLASH_COMMAND, BMR_CMD_PROG);
			wait_op();
			wr(BMR_A_FPD, 8'hF0);
			wr(BMR_A_FLASH_COMMAND, BMR_CMD_PROG);
			wait_op();
			expect_rd(7'(32 * p + 5), 8'h30);
			expect_rd(7'(32 * p + 6), 8'hFF);
		end
		wr(BMR_A_FLASH_COMMAND, 8'h33);
		@(negedge ref_clk_in);
		check8({busy, sleep}, 2'b00);
		expect_rd(7'h45, 8'h30);
		$display("test flash done");
	endtask : t_flash

	task automatic t_save;
		wr(BMR_A_FLASH_COMMAND, BMR_CMD_ERASE0);
		wait_op();
		for (int i = 0; i < 32; i++)
			wr(7'(i), 8'(i) ^ 8'h96);
		wr(BMR_A_FLASH_COMMAND, BMR_CMD_SAVE);
		wait_op();
		check1(nb == 32, 1'b1);
		for (int i = 0; i < 32; i++)
			wr(7'(i), 8'h00);
		expect_rd(7'h1F, 8'h00);
		wr(BMR_A_FLASH_COMMAND, BMR_CMD_LOAD);
		wait_op();
		check1(nb == 32, 1'b1);
		for (int i = 0; i < 32; i++)
			expect_rd(7'(i), 8'(i) ^ 8'h96);
		wr(7'h00, 8'h0F);
		wr(BMR_A_FLASH_COMMAND, BMR_CMD_SAVE);
		wait_op();
		wr(7'h00, 8'hFF);
		do_reset();
		expect_rd(BMR_A_MODE, 8'h41);
		expect_rd(7'h00, 8'h06);
		expect_rd(7'h1F, 8'h89);
		$display("test save done");
	endtask : t_save

	task automatic t_sleep;
		wr(BMR_A_FLASH_COMMAND, BMR_CMD_SLEEP);
		@(negedge ref_clk_in);
		check1(sleep, 1'b1);
		expect_rd(7'h1F, 8'h89);
		check1(sleep, 1'b0);
		$display("test sleep done");
	endtask : t_sleep

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		do_reset();
		expect_rd(BMR_A_MODE, BMR_MODE_RESET);
		t_id();
		t_meas();
		t_mode();
		t_counters();
		t_slow();
		t_flash();
		t_save();
		t_sleep();
		report_and_stop();
	end
endmodule : test_battery_monitor_register_map
